// *** hw/flight_time_cfg.svh ***
/*
 * Offsets, bit positions, reset values and timing counts of the
 * flight-time unit. Assumes a 25 MHz system clock.
 */
`ifndef FLIGHT_TIME_CFG_SVH
`define FLIGHT_TIME_CFG_SVH

`define FT_ADDR_TRX_CTRL0 8'h03
`define FT_ADDR_RX_CTRL 8'h0a
`define FT_ADDR_XAH_CTRL1 8'h17
`define FT_RST_TRX_CTRL0 8'h09
`define FT_RST_RX_CTRL 8'h37
`define FT_RST_XAH_CTRL1 8'h00
`define FT_RST_RESULT 8'h00
`define FT_BIT_ENABLE 7
`define FT_BIT_CTRL0_RSVD 6
`define FT_BIT_SHIFT_HI 7
`define FT_BIT_SHIFT_LO 6
`define FT_BIT_SPC 0
`define FT_FB_CPM_FIRST 7'h73
`define FT_FB_CPM_PEAK 7'h77
`define FT_FB_CPM_LAST 7'h7c
`define FT_FB_FEC 7'h7c
`define FT_FB_STAMP_LOW 7'h7d
`define FT_FB_STAMP_MID 7'h7e
`define FT_FB_STAMP_HIGH 7'h7f
`define FT_SFD_STANDARD 8'ha7
`define FT_CLK_MHZ 25
`define FT_TICK_NUM 16
`define FT_TX_DELAY_NS 16125
`define FT_SFD_DELAY_NS 80000
`define FT_TX_DELAY_CYC ((`FT_TX_DELAY_NS * `FT_CLK_MHZ + 999) / 1000)
`define FT_SFD_DELAY_CYC ((`FT_SFD_DELAY_NS * `FT_CLK_MHZ + 999) / 1000)

`endif

// *** hw/flight_time_measurement.sv ***
/*
 * Flight-time unit: 24-bit stamp counter, event delays, result bytes at
 * the top of the frame buffer, frequency error estimate, sync shift.
 * Assumes all inputs synchronous to SYS_CLK and one-cycle event pulses.
 */
// Decided for this implementation: the strobed register port.
// How it works
// - Enabled unit raises receive-begin interrupt for every frame, even zero length.
// - A 24-bit counter ticks at 16 MHz, controlled by radio events.
// - A timer event stores the count as stamp, then clears and restarts.
// - A non-standard start delimiter only stores the count, 80 us later.
// - Stamp lands low byte first at buffer bytes 0x7D to 0x7F.
// - A rising trigger pin edge restarts the counter after 16.125 us.
// - A standard 0xA7 delimiter restarts the counter after 80 us.
// - During reception the frequency error estimate goes to byte 0x7C.
// - Estimate is signed 8-bit chip-to-chip phase drift, 180/256 degree steps.
// - Estimate is published at receive begin and refreshed at transfer end.
// - Sync timing reads at bits 7:6: normal, early, late.
// - Nine correlator magnitudes are stored at bytes 0x73 to 0x7B, the last one again at 0x7C.
// - Bytes 0x73 to 0x7F hold results; longer frames overwrite them.
// - Acknowledgement frames also get their results mapped to the buffer.
// - Control register bit 7 enables the unit; it resets to zero.
// - Ack sync correction shifts ack start by the sync indication.
// - First magnitude byte is read-only, resets to zero, 1000 ns early.
// - Magnitudes are 250 ns apart; byte 0x77 is the peak.
`include "flight_time_cfg.svh"

module flight_time_measurement #(
  parameter int COUNT_W = 24,
  parameter int TX_DELAY_CYC = `FT_TX_DELAY_CYC,
  parameter int SFD_DELAY_CYC = `FT_SFD_DELAY_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire flight_time_pkg::bus_req_t BUS,
  input wire flight_time_pkg::radio_ev_t RADIO,
  input wire flight_time_pkg::corr_mag_t CORR_MAG,
  input wire logic SLEEP_TX_TRIGGER_PIN,
  input wire logic RX_START_IRQ_EN,
  output logic [7:0] RD_DATA,
  output logic RX_START_IRQ,
  output logic [1:0] ACK_SHIFT_CORR,
  output logic FLIGHT_TIME_ENABLE
);

  localparam int RESULTS = 13;
  // Fixed wait from the third cycle after a trigger rise to its event.
  localparam int TXD_WAIT = TX_DELAY_CYC - 3;

  // Index into the result bytes, and whether an address falls there.
  function automatic logic in_results(input logic [6:0] a);
    in_results = (a >= `FT_FB_CPM_FIRST);
  endfunction

  function automatic logic [3:0] res_idx(input logic [6:0] a);
    logic [6:0] d;
    d = a - `FT_FB_CPM_FIRST;
    res_idx = d[3:0];
  endfunction

  logic [7:0] ctrl0_r;
  logic [7:0] rx_ctrl_r;
  logic [7:0] xah1_r;
  logic [7:0] fb_r [RESULTS];
  logic [COUNT_W-1:0] count_r;
  logic running_r;
  logic [4:0] acc_r;
  logic trig_d_r;
  logic tx_pend_r;
  logic [11:0] tx_cnt_r;
  flight_time_pkg::pend_t sfd_pend_r;
  logic [11:0] sfd_cnt_r;
  logic [7:0] last_phase_r;
  logic [7:0] fec_r;

  logic enabled;
  logic tick;
  logic [5:0] acc_sum;
  logic tx_rise;
  logic tx_fire;
  logic sfd_fire;
  logic restart;
  logic capture;
  logic [7:0] drift;
  logic [7:0] fec_nxt;

  assign enabled = ctrl0_r[`FT_BIT_ENABLE];
  assign tx_rise = SLEEP_TX_TRIGGER_PIN && !trig_d_r;
  assign tx_fire = tx_pend_r && (tx_cnt_r == 12'h001);
  assign sfd_fire = (sfd_pend_r != flight_time_pkg::PEND_IDLE) &&
                    (sfd_cnt_r == 12'h001);
  assign restart = tx_fire ||
    (sfd_fire && sfd_pend_r == flight_time_pkg::PEND_RESTART);
  assign capture = tx_fire || sfd_fire;
  // 16 MHz ticks out of a 25 MHz clock by a fractional accumulator.
  assign acc_sum = {1'b0, acc_r} + 6'(`FT_TICK_NUM);
  assign tick = (acc_sum >= 6'(`FT_CLK_MHZ));
  assign drift = RADIO.chip_phase - last_phase_r;
  // First-order smoothing keeps single noisy chips from dominating.
  assign fec_nxt = fec_r + 8'($signed(drift - fec_r) >>> 2);

  //////////////////////////////////////////////////////////////////////
  // Software registers.

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl0_r <= `FT_RST_TRX_CTRL0;
      xah1_r <= `FT_RST_XAH_CTRL1;
    end else if (BUS.wr && !BUS.fb_space) begin
      if (BUS.addr == `FT_ADDR_TRX_CTRL0) begin
        ctrl0_r <= BUS.wdata;
        ctrl0_r[`FT_BIT_CTRL0_RSVD] <= 1'b0;
      end
      if (BUS.addr == `FT_ADDR_XAH_CTRL1) begin
        xah1_r <= BUS.wdata;
      end
    end
  end

  // Shift field is hardware-owned; software writes only the low bits.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_ctrl_r <= `FT_RST_RX_CTRL;
    end else begin
      if (BUS.wr && !BUS.fb_space && BUS.addr == `FT_ADDR_RX_CTRL) begin
        rx_ctrl_r[`FT_BIT_SHIFT_LO-1:0] <= BUS.wdata[`FT_BIT_SHIFT_LO-1:0];
      end
      if (RADIO.sfd_det) begin
        rx_ctrl_r[`FT_BIT_SHIFT_HI:`FT_BIT_SHIFT_LO] <= RADIO.sync_shift;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RD_DATA <= 8'h00;
    end else if (!BUS.rd) begin
      RD_DATA <= 8'h00;
    end else if (BUS.fb_space) begin
      RD_DATA <= in_results(BUS.addr[6:0]) ?
                 fb_r[res_idx(BUS.addr[6:0])] : 8'h00;
    end else begin
      unique case (BUS.addr)
        `FT_ADDR_TRX_CTRL0: RD_DATA <= ctrl0_r;
        `FT_ADDR_RX_CTRL: RD_DATA <= rx_ctrl_r;
        `FT_ADDR_XAH_CTRL1: RD_DATA <= xah1_r;
        default: RD_DATA <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Event delays. Disabling the unit drops any pending event.

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      trig_d_r <= 1'b0;
      tx_pend_r <= 1'b0;
      tx_cnt_r <= 12'h000;
    end else begin
      trig_d_r <= SLEEP_TX_TRIGGER_PIN;
      if (!enabled) begin
        tx_pend_r <= 1'b0;
      end else if (tx_rise) begin
        tx_pend_r <= 1'b1;
        tx_cnt_r <= 12'(TX_DELAY_CYC);
      end else if (tx_pend_r) begin
        tx_cnt_r <= tx_cnt_r - 12'h001;
        tx_pend_r <= !tx_fire;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sfd_pend_r <= flight_time_pkg::PEND_IDLE;
      sfd_cnt_r <= 12'h000;
    end else if (!enabled) begin
      sfd_pend_r <= flight_time_pkg::PEND_IDLE;
    end else if (RADIO.sfd_det) begin
      sfd_cnt_r <= 12'(SFD_DELAY_CYC);
      if (RADIO.sfd_value == `FT_SFD_STANDARD) begin
        sfd_pend_r <= flight_time_pkg::PEND_RESTART;
      end else begin
        sfd_pend_r <= flight_time_pkg::PEND_CAPTURE;
      end
    end else if (sfd_fire) begin
      sfd_pend_r <= flight_time_pkg::PEND_IDLE;
    end else if (sfd_pend_r != flight_time_pkg::PEND_IDLE) begin
      sfd_cnt_r <= sfd_cnt_r - 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Stamp counter. Idle after reset until the first restart event.

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count_r <= '0;
      running_r <= 1'b0;
      acc_r <= 5'h00;
    end else if (restart) begin
      count_r <= '0;
      running_r <= 1'b1;
      acc_r <= 5'h00;
    end else begin
      acc_r <= tick ? 5'(acc_sum - 6'(`FT_CLK_MHZ)) : acc_sum[4:0];
      if (running_r && tick) begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Frequency error estimate from successive chip phases.

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      last_phase_r <= 8'h00;
      fec_r <= 8'h00;
    end else if (RADIO.chip_valid) begin
      last_phase_r <= RADIO.chip_phase;
      fec_r <= fec_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Result bytes at the top of the frame buffer. Later writes win:
  // received data, then magnitudes, estimate, stamp.

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < RESULTS; i++) begin
        fb_r[i] <= `FT_RST_RESULT;
      end
    end else begin
      if (RADIO.psdu_wr && in_results(RADIO.psdu_addr)) begin
        fb_r[res_idx(RADIO.psdu_addr)] <= RADIO.psdu_data;
      end
      // Any frame type, acknowledgements included, refreshes results.
      if (enabled && RADIO.sfd_det) begin
        for (int i = 0; i < 9; i++) begin
          fb_r[i] <= CORR_MAG[i];
        end
        // The last magnitude also sits in the estimate byte until the
        // estimate is published there at receive begin.
        fb_r[res_idx(`FT_FB_CPM_LAST)] <= CORR_MAG[8];
      end
      if (enabled && (RADIO.rx_start || RADIO.transfer_done_event)) begin
        fb_r[res_idx(`FT_FB_FEC)] <= fec_r;
      end
      if (enabled && capture) begin
        fb_r[res_idx(`FT_FB_STAMP_LOW)] <= count_r[7:0];
        fb_r[res_idx(`FT_FB_STAMP_MID)] <= count_r[15:8];
        fb_r[res_idx(`FT_FB_STAMP_HIGH)] <= count_r[23:16];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt, ack start correction and status outputs.

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RX_START_IRQ <= 1'b0;
      ACK_SHIFT_CORR <= 2'b00;
      FLIGHT_TIME_ENABLE <= 1'b0;
    end else begin
      RX_START_IRQ <= RADIO.rx_start && RX_START_IRQ_EN &&
                      (enabled || !RADIO.phr_zero);
      ACK_SHIFT_CORR <= (xah1_r[`FT_BIT_SPC] && RADIO.auto_ack_rx_state) ?
        rx_ctrl_r[`FT_BIT_SHIFT_HI:`FT_BIT_SHIFT_LO] : 2'b00;
      FLIGHT_TIME_ENABLE <= enabled;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  irq_zero_len_a: assert property (
    RADIO.rx_start && RX_START_IRQ_EN && enabled |=> RX_START_IRQ)
    else $error("receive-begin interrupt missing");

  count_step_a: assert property (
    running_r && tick && !restart |=> count_r == $past(count_r) + 1'b1)
    else $error("counter did not step on tick");

  count_wrap_a: assert property (
    running_r && tick && !restart && (&count_r) |=> count_r == '0)
    else $error("counter did not wrap");

  restart_a: assert property (
    restart |=> count_r == '0 && running_r)
    else $error("counter not restarted");

  capture_only_a: assert property (
    sfd_fire && !restart && running_r && tick
    |=> count_r == $past(count_r) + 1'b1)
    else $error("capture-only event disturbed counter");

  tx_delay_a: assert property (
    enabled && tx_rise ##1 (enabled && !tx_rise)[*3] |-> ##[TXD_WAIT:TXD_WAIT]
    (tx_fire || !enabled))
    else $error("transmit event delay wrong");

  stamp_map_a: assert property (
    enabled && capture |=>
    fb_r[10] == $past(count_r[7:0]) && fb_r[12] == $past(count_r[23:16]))
    else $error("stamp bytes wrong");

  fec_publish_a: assert property (
    enabled && RADIO.transfer_done_event && !capture |=> fb_r[9] == $past(fec_r))
    else $error("frequency estimate not published");

  shift_field_a: assert property (
    RADIO.sfd_det |=> rx_ctrl_r[7:6] == $past(RADIO.sync_shift))
    else $error("sync shift not reported");

  cpm_store_a: assert property (
    enabled && RADIO.sfd_det |=> fb_r[0] == $past(CORR_MAG[0]) &&
    fb_r[4] == $past(CORR_MAG[4]))
    else $error("correlator magnitudes not stored");

  ack_corr_a: assert property (
    !xah1_r[0] |=> ACK_SHIFT_CORR == 2'b00)
    else $error("ack correction without enable");

  irq_source_a: assert property (
    RX_START_IRQ |-> $past(RADIO.rx_start && RX_START_IRQ_EN))
    else $error("receive-begin interrupt without frame");

  irq_off_a: assert property (
    !RX_START_IRQ_EN |=> !RX_START_IRQ)
    else $error("receive-begin interrupt while masked");

  sfd_arm_a: assert property (
    enabled && RADIO.sfd_det |=> sfd_cnt_r == 12'(SFD_DELAY_CYC))
    else $error("delimiter delay not armed");

  sfd_kind_a: assert property (
    enabled && RADIO.sfd_det && RADIO.sfd_value != `FT_SFD_STANDARD
    |=> sfd_pend_r == flight_time_pkg::PEND_CAPTURE)
    else $error("odd delimiter would restart counter");

  disable_drop_a: assert property (
    !enabled |=> !tx_pend_r && sfd_pend_r == flight_time_pkg::PEND_IDLE)
    else $error("pending event kept while disabled");

  ctrl_write_a: assert property (
    BUS.wr && !BUS.fb_space && BUS.addr == `FT_ADDR_TRX_CTRL0
    |=> enabled == $past(BUS.wdata[`FT_BIT_ENABLE]) &&
    !ctrl0_r[`FT_BIT_CTRL0_RSVD])
    else $error("enable bit write not taken");

  psdu_write_a: assert property (
    RADIO.psdu_wr && in_results(RADIO.psdu_addr) && !capture &&
    !(enabled && (RADIO.sfd_det || RADIO.rx_start || RADIO.transfer_done_event))
    |=> fb_r[res_idx($past(RADIO.psdu_addr))] == $past(RADIO.psdu_data))
    else $error("received data not written to result bytes");

  cpm_last_a: assert property (
    enabled && RADIO.sfd_det && !RADIO.rx_start && !RADIO.transfer_done_event
    |=> fb_r[9] == $past(CORR_MAG[8]))
    else $error("last magnitude not stored");

  count_idle_a: assert property (
    !running_r && !restart |=> count_r == '0)
    else $error("counter moved before first start");

endmodule // flight_time_measurement

// *** hw/flight_time_pkg.sv ***
/*
 * Types shared by the flight-time unit and its bench.
 * Assumes the constants of flight_time_cfg.svh.
 */
package flight_time_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic fb_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic rx_start;
    logic phr_zero;
    logic sfd_det;
    logic [7:0] sfd_value;
    logic [1:0] sync_shift;
    logic transfer_done_event;
    logic chip_valid;
    logic [7:0] chip_phase;
    logic psdu_wr;
    logic [6:0] psdu_addr;
    logic [7:0] psdu_data;
    logic auto_ack_rx_state;
  } radio_ev_t;

  typedef logic [8:0][7:0] corr_mag_t;

  typedef enum logic [1:0] {
    PEND_IDLE = 2'b00,
    PEND_RESTART = 2'b01,
    PEND_CAPTURE = 2'b10
  } pend_t;

endpackage

// *** sim/flight_time_measurement_tb.sv ***
/*
 * Self-checking bench of the flight-time unit with short event delays.
 * Assumes host_model drives the register port.
 */
`define CHK(g, e) check(g, e)
module flight_time_measurement_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic fb; logic [7:0] a; logic [7:0] d;} row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b0;
  logic irq_en = 1'b1;
  flight_time_pkg::bus_req_t bus;
  flight_time_pkg::radio_ev_t radio = '0;
  flight_time_pkg::corr_mag_t mag;
  logic [7:0] rdata, q;
  logic irq, ena;
  logic [1:0] corr;
  logic [23:0] t;
  int bad_count = 0;
  int num_checks = 0;
  row_t rows[16] = '{'{0, 0, 8'h03, 8'h09}, '{0, 0, 8'h0a, 8'h37},
    '{0, 0, 8'h17, 8'h00}, '{0, 1, 8'h73, 8'h00}, '{0, 1, 8'h7d, 8'h00},
    '{0, 1, 8'h7f, 8'h00}, '{1, 0, 8'h03, 8'hc9}, '{0, 0, 8'h03, 8'h89},
    '{1, 0, 8'h0a, 8'hff}, '{0, 0, 8'h0a, 8'h3f}, '{1, 1, 8'h73, 8'h5a},
    '{0, 1, 8'h73, 8'h00}, '{1, 0, 8'h55, 8'hff}, '{0, 0, 8'h55, 8'h00},
    '{1, 0, 8'h17, 8'h01}, '{0, 0, 8'h17, 8'h01}};

  always #20 clk = ~clk;

  flight_time_measurement #(.TX_DELAY_CYC(8), .SFD_DELAY_CYC(20)) dut (
    .SYS_CLK(clk), .RESET_N(rst_n), .BUS(bus), .RADIO(radio),
    .CORR_MAG(mag), .SLEEP_TX_TRIGGER_PIN(pin), .RX_START_IRQ_EN(irq_en),
    .RD_DATA(rdata), .RX_START_IRQ(irq), .ACK_SHIFT_CORR(corr),
    .FLIGHT_TIME_ENABLE(ena));
  host_model host (.SYS_CLK(clk), .RD_DATA(rdata), .BUS(bus));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic fb, input logic [7:0] a,
                    output logic [7:0] d);
    host.xfer(1'b0, fb, a, 8'h00, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, 1'b0, a, d, q);
  endtask
  // Kind 0 delimiter, 1 trigger pin, 2 receive begin, 3 transfer end.
  task automatic ev(input int k, input logic [7:0] v, input logic [1:0] s);
    @(posedge clk);
    radio.sfd_det <= k == 0;
    radio.sfd_value <= v;
    radio.sync_shift <= s;
    pin <= k == 1;
    radio.rx_start <= k == 2;
    radio.phr_zero <= s[0];
    radio.transfer_done_event <= k == 3;
    @(posedge clk);
    radio.sfd_det <= 1'b0;
    pin <= 1'b0;
    radio.rx_start <= 1'b0;
    radio.transfer_done_event <= 1'b0;
  endtask
  task automatic stamp();
    rd(1'b1, 8'h7d, t[7:0]);
    rd(1'b1, 8'h7e, t[15:8]);
    rd(1'b1, 8'h7f, t[23:16]);
  endtask
  // Equal phase steps settle the estimate at a known fixed point.
  task automatic chips(input logic [7:0] step);
    for (int i = 1; i <= 30; i++) begin
      @(posedge clk);
      radio.chip_valid <= 1'b1;
      radio.chip_phase <= 8'(i * step);
    end
    @(posedge clk);
    radio.chip_valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    bad_count++;
    test_done();
  end

  initial begin
    for (int i = 0; i < 9; i++) mag[i] = 8'(8'h11 + i);
    radio.auto_ack_rx_state = 1'b1;
    cyc(10);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      host.xfer(rows[i].w, rows[i].fb, rows[i].a, rows[i].d, q);
      if (!rows[i].w) `CHK(q, rows[i].d);
    end
    `CHK(ena, 1'b1);
    $display("register table done");
    // Spans of 250 or 251 clocks both give 160 ticks at 16/25 per clock.
    ev(0, 8'ha7, 2'd2);
    cyc(249);
    ev(0, 8'h11, 2'd2);
    cyc(248);
    ev(0, 8'h11, 2'd2);
    cyc(30);
    stamp();
    `CHK(t, 24'h000140);
    ev(0, 8'ha7, 2'd2);
    cyc(249);
    ev(0, 8'h11, 2'd2);
    cyc(30);
    stamp();
    `CHK(t, 24'h0000a0);
    ev(0, 8'ha7, 2'd2);
    cyc(261);
    ev(1, 8'h00, 2'd0);
    cyc(237);
    ev(0, 8'h11, 2'd2);
    cyc(30);
    stamp();
    `CHK(t, 24'h0000a0);
    $display("event stamps done");
    for (int i = 0; i < 10; i++) begin
      rd(1'b1, 8'(8'h73 + i), q);
      `CHK(q, 8'(8'h11 + (i < 9 ? i : 8)));
    end
    rd(1'b0, 8'h0a, q);
    `CHK(q, 8'hbf);
    `CHK(corr, 2'd2);
    @(posedge clk);
    radio.auto_ack_rx_state <= 1'b0;
    cyc(2);
    @(negedge clk);
    `CHK(corr, 2'd0);
    @(posedge clk);
    radio.auto_ack_rx_state <= 1'b1;
    $display("correlator and shift done");
    chips(8'h40);
    ev(2, 8'h00, 2'd1);
    @(negedge clk);
    `CHK(irq, 1'b1);
    rd(1'b1, 8'h7c, q);
    `CHK(q, 8'h3d);
    chips(8'hc0);
    rd(1'b1, 8'h7c, q);
    `CHK(q, 8'h3d);
    ev(3, 8'h00, 2'd0);
    cyc(2);
    rd(1'b1, 8'h7c, q);
    `CHK(q, 8'hc0);
    $display("estimate and interrupt done");
    wr(8'h17, 8'h00);
    wr(8'h03, 8'h09);
    cyc(2);
    `CHK(corr, 2'd0);
    `CHK(ena, 1'b0);
    ev(2, 8'h00, 2'd1);
    @(negedge clk);
    `CHK(irq, 1'b0);
    ev(1, 8'h00, 2'd0);
    cyc(20);
    stamp();
    `CHK(t, 24'h0000a0);
    $display("disabled unit done");
    // Transmit start, then the whole 127-octet frame written behind it.
    wr(8'h03, 8'h89);
    ev(1, 8'h00, 2'd0);
    for (int i = 0; i < 127; i++) begin
      @(posedge clk);
      radio.psdu_wr <= 1'b1;
      radio.psdu_addr <= 7'(i);
      radio.psdu_data <= 8'(i ^ 8'h5a);
    end
    @(posedge clk);
    radio.psdu_wr <= 1'b0;
    rd(1'b1, 8'h73, q);
    `CHK(q, 8'h29);
    rd(1'b1, 8'h7e, q);
    `CHK(q, 8'h24);
    $display("long frame done");
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rd(1'b0, 8'h03, q);
    `CHK(q, 8'h09);
    rd(1'b1, 8'h73, q);
    `CHK(q, 8'h00);
    `CHK(ena, 1'b0);
    $display("mid-run reset done");
    test_done();
  end
endmodule // flight_time_measurement_tb

// *** sim/host_model.sv ***
/*
 * Host side of the register port: one task moves one byte either way.
 * Assumes the device answers a read in the cycle after the strobe.
 */
module host_model (
  input wire logic SYS_CLK,
  input wire logic [7:0] RD_DATA,
  output flight_time_pkg::bus_req_t BUS
);
  timeunit 1ns;
  timeprecision 1ps;
  initial BUS = '0;
  // The result bytes are read-only from this port; long frames still write them through the radio side.
  task automatic xfer(input logic w, input logic fb, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge SYS_CLK);
    BUS <= '{wr: w, rd: !w, fb_space: fb, addr: a, wdata: d};
    @(posedge SYS_CLK);
    BUS <= '0;
    @(negedge SYS_CLK);
    q = RD_DATA;
  endtask
endmodule // host_model
